// *** rtl/freq_mon_pkg.sv ***
// package: register map, field layout and codes of the clock accuracy monitor
// assumes: used by the monitor top only; the edge sampler does not import it
package freq_mon_pkg;
  // ==========================================
  // register offsets (byte addresses)
  localparam logic [3:0] OFS_CONTROL_ONE = 4'h0;
  localparam logic [3:0] OFS_CONTROL_TWO = 4'h4;
  localparam logic [3:0] OFS_CONTROL_THREE = 4'h8;
  localparam logic [3:0] OFS_STATUS = 4'hC;
  localparam logic [7:0] OFS_LIMIT_LOW = 8'h10;
  localparam logic [7:0] OFS_LIMIT_HIGH = 8'h14;
  localparam logic [7:0] OFS_RESULT = 8'h18;
  localparam logic [7:0] OFS_INT_MASK = 8'h1C;
  // ==========================================
  // field positions
  localparam int POS_ENABLE = 0;
  localparam int POS_SEL_LSB = 1;
  localparam int POS_SEL_MSB = 3;
  localparam int POS_REF_EXT = 0;
  localparam int POS_FILTER = 4;
  localparam int POS_STOP = 0;
  localparam int POS_WINDOW_LSB = 1;
  localparam int POS_WINDOW_MSB = 3;
  // status bits
  localparam int ST_DONE = 0;
  localparam int ST_FERR = 1;
  localparam int ST_OVF = 2;
  // ==========================================
  // reset values
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [7:0] RST_CONTROL_THREE = 8'h01;
  localparam logic [15:0] RST_LIMIT_LOW = 16'h0000;
  localparam logic [15:0] RST_LIMIT_HIGH = 16'hFFFF;
  localparam logic [2:0] RST_INT_MASK = 3'h0;
  // ==========================================
  // clock source codes
  typedef enum logic [2:0] {
    SRC_MAIN = 3'h0,
    SRC_SUB = 3'h1,
    SRC_HIGH_SPEED = 3'h2,
    SRC_LOW_SPEED = 3'h3,
    SRC_WATCHDOG = 3'h4,
    SRC_PERIPH_B = 3'h5
  } clk_src_e;
  localparam int NUM_SRC = 6;
  // filter needs this many equal samples
  localparam int FILTER_LEN = 3;
endpackage

// *** rtl/edge_sampler.sv ***
// holds: three-stage synchroniser with rising edge detection
// assumes: source is asynchronous to clk
`timescale 1ns/1ps
module edge_sampler
(
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // async input and synchronised result
  input wire logic async_in,
  output logic level,
  output logic rise
);
  logic s1;
  logic s2;
  logic s3;
  logic held;
  // ==========================================
  // capture chain; change counts once s2 and s3 agree
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      s1 <= 1'b0;
      s2 <= 1'b0;
      s3 <= 1'b0;
      held <= 1'b0;
    end
    else
    begin
      s1 <= async_in;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3)
        held <= s3;
    end
  end
  // rising edge of the agreed level
  assign rise = (s2 == s3) && s3 && !held;
  assign level = held;
endmodule

// *** rtl/freq_mon.sv ***
// holds: clock frequency accuracy monitor with register port and interrupt
// assumes: all source clocks far slower than clk, sampled as plain inputs
// ==========================================
`timescale 1ns/1ps
module freq_mon
#(
  parameter int COUNT_W = 16
)
(
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // clocks to measure or use as reference
  input wire logic [freq_mon_pkg::NUM_SRC-1:0] source_clock,
  input wire logic external_reference_pin,
  // register port
  input wire logic [7:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [15:0] rdata,
  // interrupt
  output logic irq
);
  import freq_mon_pkg::*;

  // refuse counter widths that the result register cannot hold
  if (COUNT_W < 4 || COUNT_W > 16)
  begin : g_bad_count_w
    $error("COUNT_W must lie in 4..16");
  end

  // ==========================================
  // registers
  logic [7:0] measure_control_one;
  logic [7:0] measure_control_two;
  logic [7:0] control_three;
  logic [15:0] limit_low;
  logic [15:0] limit_high;
  logic [15:0] result;
  logic [2:0] status;
  logic [2:0] int_mask;
  logic [COUNT_W-1:0] count;
  logic [2:0] ref_periods;
  logic [1:0] filt_cnt;
  logic ref_filt;
  logic ref_filt_d;
  logic meas_active;

  // ==========================================
  // synchronise every clock source
  logic [NUM_SRC-1:0] src_rise;
  logic ext_rise;
  logic ext_level;
  genvar g;
  generate
    for (g = 0; g < NUM_SRC; g++)
    begin : g_src
      edge_sampler u_smp (
        .clk(clk),
        .arst_n(arst_n),
        .async_in(source_clock[g]),
        .level(),
        .rise(src_rise[g])
      );
    end
  endgenerate
  edge_sampler u_ext (
    .clk(clk),
    .arst_n(arst_n),
    .async_in(external_reference_pin),
    .level(ext_level),
    .rise(ext_rise)
  );

  // ==========================================
  // decode and selection
  wire [2:0] target_clock_select = measure_control_one[POS_SEL_MSB:POS_SEL_LSB];
  wire [2:0] reference_clock_select = measure_control_two[POS_SEL_MSB:POS_SEL_LSB];
  wire meas_enable = measure_control_one[POS_ENABLE];
  wire ref_external = measure_control_two[POS_REF_EXT];
  wire filter_on = measure_control_two[POS_FILTER];
  wire module_stop = control_three[POS_STOP];
  wire [2:0] window_periods = control_three[POS_WINDOW_MSB:POS_WINDOW_LSB];
  wire running = meas_enable && !module_stop;
  // unlisted codes read as no edge at all
  wire tgt_legal = target_clock_select < 3'(NUM_SRC);
  wire ref_legal = reference_clock_select < 3'(NUM_SRC);
  wire tgt_edge = tgt_legal && src_rise[target_clock_select];
  wire int_edge = ref_legal && src_rise[reference_clock_select];
  // filtered external level, rising edge
  wire ext_edge = filter_on ? (ref_filt && !ref_filt_d) : ext_rise;
  wire ref_edge = ref_external ? ext_edge : int_edge;
  wire at_max = &count;
  wire window_end = ref_edge && meas_active && (ref_periods == window_periods);
  wire [15:0] count_ext = 16'(count);
  wire out_of_range = (count_ext < limit_low) || (count_ext > limit_high);
  wire ev_done = running && window_end;
  wire ev_ferr = ev_done && out_of_range;
  wire ev_ovf = running && meas_active && tgt_edge && at_max;
  wire [2:0] events = {ev_ovf, ev_ferr, ev_done};
  wire wr_ctl1 = wr && (addr == {4'h0, OFS_CONTROL_ONE});
  wire wr_ctl2 = wr && (addr == {4'h0, OFS_CONTROL_TWO});
  wire wr_ctl3 = wr && (addr == {4'h0, OFS_CONTROL_THREE});
  wire wr_stat = wr && (addr == {4'h0, OFS_STATUS});
  wire wr_lo = wr && (addr == OFS_LIMIT_LOW);
  wire wr_hi = wr && (addr == OFS_LIMIT_HIGH);
  wire wr_mask = wr && (addr == OFS_INT_MASK);

  // ==========================================
  // control registers
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      measure_control_one <= RST_CONTROL;
      measure_control_two <= RST_CONTROL;
      control_three <= RST_CONTROL_THREE;
      limit_low <= RST_LIMIT_LOW;
      limit_high <= RST_LIMIT_HIGH;
      int_mask <= RST_INT_MASK;
    end
    else
    begin
      if (wr_ctl1)
        measure_control_one <= {4'h0, wdata[3:0]};
      if (wr_ctl2)
        measure_control_two <= {3'h0, wdata[4:0]};
      if (wr_ctl3)
        control_three <= {4'h0, wdata[3:0]};
      if (wr_lo)
        limit_low <= wdata;
      if (wr_hi)
        limit_high <= wdata;
      if (wr_mask)
        int_mask <= wdata[2:0];
    end
  end

  // ==========================================
  // sticky status, write one to clear, set wins
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      status <= 3'h0;
    else
      status <= (status & ~(wr_stat ? wdata[2:0] : 3'h0)) | events;
  end
  assign irq = |(status & int_mask);

  // ==========================================
  // noise filter on external reference
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      filt_cnt <= 2'h0;
      ref_filt <= 1'b0;
      ref_filt_d <= 1'b0;
    end
    else if (!module_stop)
    begin
      ref_filt_d <= ref_filt;
      if (ext_level == ref_filt)
        filt_cnt <= 2'h0;
      else if (filt_cnt == 2'(FILTER_LEN - 1))
      begin
        ref_filt <= ext_level;
        filt_cnt <= 2'h0;
      end
      else
        filt_cnt <= filt_cnt + 2'h1;
    end
  end

  // ==========================================
  // measurement: window opens on a reference edge, spans periods
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      meas_active <= 1'b0;
      ref_periods <= 3'h0;
      count <= '0;
      result <= 16'h0000;
    end
    else if (!running)
    begin
      meas_active <= 1'b0;
      ref_periods <= 3'h0;
      count <= '0;
    end
    else if (ref_edge && !meas_active)
    begin
      meas_active <= 1'b1;
      ref_periods <= 3'h0;
      count <= '0;
    end
    else if (window_end)
    begin
      result <= count_ext;
      ref_periods <= 3'h0;
      count <= '0; // back-to-back windows
    end
    else
    begin
      if (ref_edge && meas_active)
        ref_periods <= ref_periods + 3'h1;
      if (tgt_edge && meas_active && !at_max)
        count <= count + COUNT_W'(1);
    end
  end

  // ==========================================
  // read data, one cycle after strobe
  logic [15:0] next_rdata;
  always_comb
  begin
    next_rdata = 16'h0000;
    unique case (addr)
      {4'h0, OFS_CONTROL_ONE}: next_rdata = {8'h00, measure_control_one};
      {4'h0, OFS_CONTROL_TWO}: next_rdata = {8'h00, measure_control_two};
      {4'h0, OFS_CONTROL_THREE}: next_rdata = {8'h00, control_three};
      {4'h0, OFS_STATUS}: next_rdata = {13'h0000, status};
      OFS_LIMIT_LOW: next_rdata = limit_low;
      OFS_LIMIT_HIGH: next_rdata = limit_high;
      OFS_RESULT: next_rdata = result;
      OFS_INT_MASK: next_rdata = {13'h0000, int_mask};
      default: next_rdata = 16'h0000;
    endcase
  end
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      rdata <= 16'h0000;
    else
      rdata <= rd ? next_rdata : 16'h0000;
  end

  // ==========================================
  // checks
  // named steps of a measurement window
  sequence seq_window_close;
    running && window_end;
  endsequence
  sequence seq_window_fresh;
    meas_active && (count == '0) && (ref_periods == 3'h0);
  endsequence
  sequence seq_count_step;
    running && meas_active && !window_end && !at_max
      && tgt_legal && src_rise[target_clock_select];
  endsequence
  // module stop closes the window and freezes the filter
  AST_STOP_IDLE: assert property (@(posedge clk) disable iff (!arst_n)
    module_stop |=> !meas_active)
    else $error("measurement runs in module stop");
  AST_STOP_FILTER: assert property (@(posedge clk) disable iff (!arst_n)
    module_stop |=> $stable(ref_filt))
    else $error("filter moves in module stop");
  // flags, interrupt and filter
  AST_DONE_SET: assert property (@(posedge clk) disable iff (!arst_n)
    ev_done |=> status[ST_DONE])
    else $error("done flag not set");
  AST_FERR_RANGE: assert property (@(posedge clk) disable iff (!arst_n)
    $rose(status[ST_FERR]) |-> $past(out_of_range))
    else $error("range error without cause");
  AST_OVF_SET: assert property (@(posedge clk) disable iff (!arst_n)
    ev_ovf |=> status[ST_OVF])
    else $error("overflow flag not set");
  AST_STATUS_CLEAR: assert property (@(posedge clk) disable iff (!arst_n)
    wr_stat && wdata[ST_DONE] && !ev_done |=> !status[ST_DONE])
    else $error("done flag not cleared");
  AST_IRQ: assert property (@(posedge clk) disable iff (!arst_n)
    $rose(irq) |-> ($past(|events) || $past(wr_mask)))
    else $error("irq rises without event or mask write");
  AST_FILTER_FLIP: assert property (@(posedge clk) disable iff (!arst_n)
    $changed(ref_filt) |-> $past(filt_cnt) == 2'(FILTER_LEN - 1))
    else $error("filter flips too early");
  // window and counting
  AST_RESULT: assert property (@(posedge clk) disable iff (!arst_n)
    ev_done |=> result == $past(count_ext))
    else $error("result not latched");
  AST_RESULT_HOLD: assert property (@(posedge clk) disable iff (!arst_n)
    !ev_done |=> $stable(result))
    else $error("result changes outside window end");
  AST_WINDOW_AGAIN: assert property (@(posedge clk) disable iff (!arst_n)
    seq_window_close |=> seq_window_fresh)
    else $error("window does not start over");
  AST_COUNT_STEP: assert property (@(posedge clk) disable iff (!arst_n)
    seq_count_step |=> count == $past(count) + COUNT_W'(1))
    else $error("target edge not counted");
  AST_TGT_ILLEGAL: assert property (@(posedge clk) disable iff (!arst_n)
    !tgt_legal |=> count == '0 || $stable(count))
    else $error("count moves on illegal code");
  // reference path
  AST_REF_SRC: assert property (@(posedge clk) disable iff (!arst_n)
    (!ref_external && ref_legal && src_rise[reference_clock_select]) |-> ref_edge)
    else $error("internal reference edge lost");
  AST_REF_EXT: assert property (@(posedge clk) disable iff (!arst_n)
    (ref_external && !filter_on && ext_rise) |-> ref_edge)
    else $error("external reference edge lost");
endmodule

// *** test/clk_sources.sv ***
// holds: model of the on-chip clock sources and the reference pin
// assumes: periods in ns, all far slower than the system clock
`timescale 1ns/1ps
module clk_sources
(
  // control
  input wire logic ref_on,
  // clocks
  output logic [5:0] source_clock,
  output logic external_reference_pin
);
  localparam int HALF [6] = '{70, 100, 140, 200, 280, 400};
  // ======================
  // on-chip clocks, each free running at its own rate
  for (genvar i = 0; i < 6; i++)
  begin : g_src
    initial source_clock[i] = 1'b0;
    always #(HALF[i]) source_clock[i] = ~source_clock[i];
  end
  // external pin, stands low while off
  initial external_reference_pin = 1'b0;
  always #2000 external_reference_pin = ref_on & ~external_reference_pin;
endmodule

// *** test/test_clock_freq_accuracy_monitor.sv ***
// holds: self-checking bench of the clock accuracy monitor
// assumes: source model clk_sources, register map of the hand-over
`timescale 1ns/1ps
`define CHK(a, e) \
  begin \
    total_checks++; \
    if ((a) !== (e)) \
    begin \
      bad_count++; \
      $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); \
    end \
  end
module test_clock_freq_accuracy_monitor;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic ref_on = 1'b0;
  wire [5:0] source_clock;
  wire ext_pin;
  wire [15:0] rdata;
  wire irq;
  int bad_count = 0;
  int total_checks = 0;
  int seed = 32'hee3b;
  int per [6] = '{140, 200, 280, 400, 560, 800};
  // window lengths in ns: two pin periods, eight watchdog periods
  localparam int EXT_WIN = 8000;
  localparam int INT_WIN = 4480;
  logic [7:0] ra [8] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h1C, 8'h20};
  logic [15:0] rv [8] = '{16'h0000, 16'h0000, 16'h0001, 16'h0000, 16'h0000,
    16'hFFFF, 16'h0000, 16'h0000};
  logic [15:0] v;
  logic [15:0] r [6];
  // ======================
  // clock and parts
  always #10 clk = ~clk;
  freq_mon #(.COUNT_W(7)) uut (.clk(clk), .arst_n(arst_n), .source_clock(source_clock),
    .external_reference_pin(ext_pin), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .irq(irq));
  clk_sources src (.ref_on(ref_on), .source_clock(source_clock),
    .external_reference_pin(ext_pin));
  // ======================
  // verdict
  task automatic wrap_up;
    $display("checks=%0d errors=%0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // register port cycles
  task automatic wr_reg(input logic [7:0] a, input logic [15:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk) wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [15:0] d);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk) rd <= 1'b0;
    @(negedge clk) d = rdata;
    @(posedge clk);
  endtask
  // count within two periods plus 280 ns of the window seen by another clock
  function automatic logic near(input logic [15:0] c, input int p, input int t);
    int d;
    d = int'(c) * p - t;
    return d <= 2 * p + 280 && -d <= 2 * p + 280;
  endfunction
  // select target, skip the first window, take the second
  task automatic measure(input logic [2:0] t, output logic [15:0] res);
    logic [15:0] s;
    int n;
    wr_reg(8'h00, {12'h000, t, 1'b1});
    wr_reg(8'h0C, 16'h0007);
    for (int k = 0; k < 2; k++)
    begin
      n = 0;
      s = 16'h0000;
      while (s[0] !== 1'b1)
      begin
        rd_reg(8'h0C, s);
        n++;
        if (n > 3000)
        begin
          bad_count++;
          wrap_up();
        end
      end
      if (k == 0)
        wr_reg(8'h0C, 16'h0001);
    end
    rd_reg(8'h18, res);
  endtask
  // ======================
  // main sequence
  initial
  begin
    repeat (3) @(posedge clk);
    `CHK(irq, 1'b0)
    arst_n <= 1'b1;
    @(posedge clk);
    wr_reg(8'h20, 16'hFFFF);
    for (int i = 0; i < 8; i++)
    begin
      rd_reg(ra[i], v);
      `CHK(v, rv[i])
    end
    // random upper limits read back
    repeat (4)
    begin
      v = 16'($random(seed));
      wr_reg(8'h14, v);
      rd_reg(8'h14, r[0]);
      `CHK(r[0], v)
    end
    wr_reg(8'h14, 16'hFFFF);
    // stopped module never completes
    ref_on <= 1'b1;
    wr_reg(8'h04, 16'h0011);
    wr_reg(8'h00, 16'h0001);
    repeat (600) rd_reg(8'h0C, v);
    `CHK(v[0], 1'b0)
    wr_reg(8'h08, 16'h0002);
    // every target against the external pin
    for (int i = 0; i < 6; i++)
    begin
      measure(3'(i), r[i]);
      `CHK(near(r[i], per[i], EXT_WIN), 1'b1)
    end
    // mask, raise, clear
    `CHK(irq, 1'b0)
    wr_reg(8'h1C, 16'h0001);
    `CHK(irq, 1'b1)
    wr_reg(8'h0C, 16'h0001);
    `CHK(irq, 1'b0)
    // count under a random high lower limit
    v = {1'b1, 15'($random(seed))};
    wr_reg(8'h10, v);
    measure(3'h2, v);
    rd_reg(8'h0C, v);
    `CHK(v[1], 1'b1)
    wr_reg(8'h10, 16'h0000);
    // long window overflows the short counter
    wr_reg(8'h08, 16'h000E);
    wr_reg(8'h04, 16'h0001);
    measure(3'h0, v);
    `CHK(v, 16'h007F)
    rd_reg(8'h0C, v);
    `CHK(v[2], 1'b1)
    // internal reference, pin idle
    ref_on <= 1'b0;
    wr_reg(8'h04, 16'h0008);
    measure(3'h0, v);
    `CHK(near(v, per[0], INT_WIN), 1'b1)
    wrap_up();
  end
endmodule
